// ==== design/dpdbsi_pkg.sv ====
package dpdbsi_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ADDR_W = 21;
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int LANE0_HI = 8;
  localparam int LANE1_LO = 9;
  localparam int LANE1_HI = 17;
  localparam int ARRAY_WORDS = 2 ** ADDR_W;

  // ****************************************************************
  // Reset values and timing counts
  // ****************************************************************
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;
  localparam logic [LANES-1:0] MASK_IDLE = 2'h3;
  // K edges after reset release before the termination strap is taken
  localparam logic [1:0] STRAP_EDGES = 2'h3;
  // Termination range codes seen on the strap pin
  localparam logic TERM_LOW_RANGE = 1'h0;
  localparam logic TERM_HIGH_RANGE = 1'h1;

  // ****************************************************************
  // Host link clock phases, four host clocks per link cycle
  // ****************************************************************
  typedef enum logic [1:0] {
    DPDBSI_PH_KRISE = 2'h0,
    DPDBSI_PH_KHIGH = 2'h1,
    DPDBSI_PH_KFALL = 2'h3,
    DPDBSI_PH_KLOW = 2'h2
  } dpdbsi_phase_t;

endpackage : dpdbsi_pkg

// ==== design/dpdbsi_link_if.sv ====
`timescale 1ns/1ns
interface dpdbsi_link_if;
  logic k;
  logic k_n;
  logic read_port_select_n;
  logic write_port_select_n;
  logic [dpdbsi_pkg::LANES-1:0] byte_lane_mask_n;
  logic [dpdbsi_pkg::ADDR_W-1:0] addr;
  logic [dpdbsi_pkg::DATA_W-1:0] wr_data;
  logic [dpdbsi_pkg::DATA_W-1:0] rd_data;
  logic rd_data_oe;
  logic output_valid_flag;
  logic return_strobe;
  logic return_strobe_n;
  wire [dpdbsi_pkg::DATA_W-1:0] rd_bus;

  // Read bus level; with the drivers off it shows the inverse of the drive value,
  // so a host that samples an undriven bus picks up wrong data
  assign rd_bus = rd_data_oe ? rd_data : ~rd_data;

  modport dev (
    input k, k_n, read_port_select_n, write_port_select_n, byte_lane_mask_n, addr, wr_data,
    output rd_data, rd_data_oe, output_valid_flag, return_strobe, return_strobe_n
  );

  modport host (
    output k, k_n, read_port_select_n, write_port_select_n, byte_lane_mask_n, addr, wr_data,
    input rd_bus, output_valid_flag, return_strobe, return_strobe_n
  );
endinterface : dpdbsi_link_if

// ==== design/dpdbsi_sync2.sv ====
`timescale 1ns/1ns
module dpdbsi_sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_r;

  // Two-stage level synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'h0;
      q <= 1'h0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : dpdbsi_sync2

// ==== design/dpdbsi_device_end.sv ====
// How it works
// - Write words captured on both clock rises
// - Low write select at K starts write
// - Deselected write port ignores write bus
// - Lane masks follow data edges, two lanes
// - Masked lane keeps its stored contents
// - Read address at K, write at K#
// - 21-bit address, two 18-bit halves
// - Deselected port ignores the address
// - Read words driven on both clock rises
// - Read bus floats while port deselected
// - Low read select at K starts read
// - Pending read finishes, then bus floats
// - Every read returns exactly two words
// - Valid flag edge-aligned with echo strobes
// - Termination range strap taken at power-up
// - All accesses launched at K rise
// - Free-running echo strobes follow K
// - PLL bypass gives one-cycle read latency
`timescale 1ns/1ns
module dpdbsi_device_end (
  dpdbsi_link_if.dev link,
  input wire logic rst_n,
  input wire logic pll_bypass_n,
  input wire logic termination_range_pin,
  output logic term_high_range
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Low half holds the first beat, high half the second beat
  logic [dpdbsi_pkg::DATA_W-1:0] mem_lo [0:dpdbsi_pkg::ARRAY_WORDS-1];
  logic [dpdbsi_pkg::DATA_W-1:0] mem_hi [0:dpdbsi_pkg::ARRAY_WORDS-1];

  // Byte-lane merge of a new beat into an old word
  function automatic logic [dpdbsi_pkg::DATA_W-1:0] dpdbsi_merge(
    input logic [dpdbsi_pkg::DATA_W-1:0] old_word,
    input logic [dpdbsi_pkg::DATA_W-1:0] new_word,
    input logic [dpdbsi_pkg::LANES-1:0] mask_n
  );
    logic [dpdbsi_pkg::DATA_W-1:0] res;
    res = new_word;
    if (mask_n[1]) begin
      res[dpdbsi_pkg::LANE1_HI:dpdbsi_pkg::LANE1_LO] =
        old_word[dpdbsi_pkg::LANE1_HI:dpdbsi_pkg::LANE1_LO];
    end
    if (mask_n[0]) begin
      res[dpdbsi_pkg::LANE0_HI:0] = old_word[dpdbsi_pkg::LANE0_HI:0];
    end
    return res;
  endfunction : dpdbsi_merge

  // ****************************************************************
  // Pin straps
  // ****************************************************************
  logic bypass_sync;
  logic term_sync;
  logic [1:0] strap_cnt_r;
  logic strap_done_r;
  logic pll_off;

  dpdbsi_sync2 u_bypass_sync (
    .clk(link.k),
    .rst_n(rst_n),
    .d(pll_bypass_n),
    .q(bypass_sync)
  );

  dpdbsi_sync2 u_term_sync (
    .clk(link.k),
    .rst_n(rst_n),
    .d(termination_range_pin),
    .q(term_sync)
  );

  assign pll_off = ~bypass_sync;

  always_ff @(posedge link.k or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'h0;
      term_high_range <= dpdbsi_pkg::TERM_HIGH_RANGE;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == dpdbsi_pkg::STRAP_EDGES) begin
        strap_done_r <= 1'h1;
        term_high_range <= (term_sync == dpdbsi_pkg::TERM_HIGH_RANGE);
      end
    end
  end

  // ****************************************************************
  // Command decode at K
  // ****************************************************************
  logic rd_take;
  logic wr_take;

  assign rd_take = ~link.read_port_select_n;
  assign wr_take = ~link.write_port_select_n;

  // ****************************************************************
  // Write path
  // ****************************************************************
  logic wpend_r;
  logic [dpdbsi_pkg::DATA_W-1:0] w0_r;
  logic [dpdbsi_pkg::LANES-1:0] m0_r;

  always_ff @(posedge link.k or negedge rst_n) begin
    if (!rst_n) begin
      wpend_r <= 1'h0;
      w0_r <= dpdbsi_pkg::DATA_RST;
      m0_r <= dpdbsi_pkg::MASK_IDLE;
    end else begin
      wpend_r <= wr_take;
      if (wr_take) begin
        w0_r <= link.wr_data;
        m0_r <= link.byte_lane_mask_n;
      end
    end
  end

  always_ff @(posedge link.k_n) begin
    if (wpend_r) begin
      mem_lo[link.addr] <= dpdbsi_merge(mem_lo[link.addr], w0_r, m0_r);
      mem_hi[link.addr] <= dpdbsi_merge(mem_hi[link.addr], link.wr_data, link.byte_lane_mask_n);
    end
  end

  // ****************************************************************
  // Read pipeline
  // ****************************************************************
  logic s1_v_r;
  logic s2_v_r;
  logic [2*dpdbsi_pkg::DATA_W-1:0] s1_d_r;
  logic [2*dpdbsi_pkg::DATA_W-1:0] s2_d_r;
  logic sel_v;
  logic [2*dpdbsi_pkg::DATA_W-1:0] sel_d;
  logic qv_k_r;
  logic qv_kn_r;
  logic [dpdbsi_pkg::DATA_W-1:0] q_lo_r;
  logic [dpdbsi_pkg::DATA_W-1:0] q_hi_k_r;
  logic [dpdbsi_pkg::DATA_W-1:0] q_hi_r;

  assign sel_v = pll_off ? s1_v_r : s2_v_r;
  assign sel_d = pll_off ? s1_d_r : s2_d_r;

  always_ff @(posedge link.k or negedge rst_n) begin
    if (!rst_n) begin
      s1_v_r <= 1'h0;
      s2_v_r <= 1'h0;
      s1_d_r <= {dpdbsi_pkg::DATA_RST, dpdbsi_pkg::DATA_RST};
      s2_d_r <= {dpdbsi_pkg::DATA_RST, dpdbsi_pkg::DATA_RST};
    end else begin
      s1_v_r <= rd_take;
      s2_v_r <= s1_v_r;
      s2_d_r <= s1_d_r;
      if (rd_take) begin
        s1_d_r <= {mem_hi[link.addr], mem_lo[link.addr]};
      end
    end
  end

  // two-word burst, first word at K
  // valid drops after the pending read
  always_ff @(posedge link.k or negedge rst_n) begin
    if (!rst_n) begin
      qv_k_r <= 1'h0;
      q_lo_r <= dpdbsi_pkg::DATA_RST;
      q_hi_k_r <= dpdbsi_pkg::DATA_RST;
    end else begin
      qv_k_r <= sel_v;
      if (sel_v) begin
        q_lo_r <= sel_d[dpdbsi_pkg::DATA_W-1:0];
        q_hi_k_r <= sel_d[2*dpdbsi_pkg::DATA_W-1:dpdbsi_pkg::DATA_W];
      end
    end
  end

  always_ff @(posedge link.k_n or negedge rst_n) begin
    if (!rst_n) begin
      qv_kn_r <= 1'h0;
      q_hi_r <= dpdbsi_pkg::DATA_RST;
    end else begin
      qv_kn_r <= qv_k_r;
      if (qv_k_r) begin
        q_hi_r <= q_hi_k_r;
      end
    end
  end

  // ****************************************************************
  // Output drivers
  // ****************************************************************
  // beat selected by clock half
  assign link.rd_data = link.k ? q_lo_r : q_hi_r;
  assign link.rd_data_oe = link.k ? qv_k_r : qv_kn_r;
  assign link.output_valid_flag = link.k ? qv_k_r : qv_kn_r;
  // echo strobes follow the input clocks
  assign link.return_strobe = link.k;
  assign link.return_strobe_n = link.k_n;

endmodule : dpdbsi_device_end

// ==== design/dpdbsi_host_end.sv ====
`timescale 1ns/1ns
module dpdbsi_host_end (
  input wire logic clk,
  input wire logic rst_n,
  dpdbsi_link_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [dpdbsi_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [2*dpdbsi_pkg::DATA_W-1:0] cmd_wdata,
  input wire logic [2*dpdbsi_pkg::LANES-1:0] cmd_mask_n,
  output logic cmd_ready,
  output logic rd_valid,
  output logic [2*dpdbsi_pkg::DATA_W-1:0] rd_data
);

  // ****************************************************************
  // Link clock divider
  // ****************************************************************
  dpdbsi_pkg::dpdbsi_phase_t ph_r;
  dpdbsi_pkg::dpdbsi_phase_t ph_nxt;
  logic k_r;
  logic kn_r;

  // Four host clocks per link cycle, Gray-coded walk
  always_comb begin
    unique case (ph_r)
      dpdbsi_pkg::DPDBSI_PH_KRISE: ph_nxt = dpdbsi_pkg::DPDBSI_PH_KHIGH;
      dpdbsi_pkg::DPDBSI_PH_KHIGH: ph_nxt = dpdbsi_pkg::DPDBSI_PH_KFALL;
      dpdbsi_pkg::DPDBSI_PH_KFALL: ph_nxt = dpdbsi_pkg::DPDBSI_PH_KLOW;
      dpdbsi_pkg::DPDBSI_PH_KLOW: ph_nxt = dpdbsi_pkg::DPDBSI_PH_KRISE;
    endcase
  end

  // Clock pair driven from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= dpdbsi_pkg::DPDBSI_PH_KLOW;
      k_r <= 1'h0;
      kn_r <= 1'h1;
    end else begin
      ph_r <= ph_nxt;
      k_r <= (ph_nxt == dpdbsi_pkg::DPDBSI_PH_KRISE) || (ph_nxt == dpdbsi_pkg::DPDBSI_PH_KHIGH);
      kn_r <= (ph_nxt == dpdbsi_pkg::DPDBSI_PH_KFALL) || (ph_nxt == dpdbsi_pkg::DPDBSI_PH_KLOW);
    end
  end

  // ****************************************************************
  // Command launch
  // ****************************************************************
  logic take;
  logic at_first;
  logic at_second;
  logic rd_sel_n_r;
  logic wr_sel_n_r;
  logic [dpdbsi_pkg::ADDR_W-1:0] addr_r;
  logic [dpdbsi_pkg::DATA_W-1:0] d_r;
  logic [dpdbsi_pkg::LANES-1:0] mask_r;
  logic [dpdbsi_pkg::DATA_W-1:0] wd1_r;
  logic [dpdbsi_pkg::LANES-1:0] wm1_r;

  // First beat set one phase before K rise, second before K# rise
  assign at_first = (ph_r == dpdbsi_pkg::DPDBSI_PH_KFALL);
  assign at_second = (ph_r == dpdbsi_pkg::DPDBSI_PH_KRISE);
  assign take = cmd_valid & cmd_ready;

  // selects and read address set up for K
  // beats on consecutive K, K# rises
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready <= 1'h0;
      rd_sel_n_r <= 1'h1;
      wr_sel_n_r <= 1'h1;
      addr_r <= dpdbsi_pkg::ADDR_RST;
      d_r <= dpdbsi_pkg::DATA_RST;
      mask_r <= dpdbsi_pkg::MASK_IDLE;
      wd1_r <= dpdbsi_pkg::DATA_RST;
      wm1_r <= dpdbsi_pkg::MASK_IDLE;
    end else begin
      cmd_ready <= (ph_nxt == dpdbsi_pkg::DPDBSI_PH_KFALL);
      if (at_first) begin
        rd_sel_n_r <= ~(take & ~cmd_write);
        wr_sel_n_r <= ~(take & cmd_write);
        addr_r <= cmd_addr;
        d_r <= cmd_wdata[dpdbsi_pkg::DATA_W-1:0];
        mask_r <= cmd_mask_n[dpdbsi_pkg::LANES-1:0];
        wd1_r <= cmd_wdata[2*dpdbsi_pkg::DATA_W-1:dpdbsi_pkg::DATA_W];
        wm1_r <= cmd_mask_n[2*dpdbsi_pkg::LANES-1:dpdbsi_pkg::LANES];
      end else if (at_second) begin
        d_r <= wd1_r;
        mask_r <= wm1_r;
      end
    end
  end

  assign link.k = k_r;
  assign link.k_n = kn_r;
  assign link.read_port_select_n = rd_sel_n_r;
  assign link.write_port_select_n = wr_sel_n_r;
  assign link.addr = addr_r;
  assign link.wr_data = d_r;
  assign link.byte_lane_mask_n = mask_r;

  // ****************************************************************
  // Read capture, steered by the valid flag
  // ****************************************************************
  logic [dpdbsi_pkg::DATA_W-1:0] rlo_r;
  logic rv_lo_r;

  // Sample mid high phase and at the end of the low phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rlo_r <= dpdbsi_pkg::DATA_RST;
      rv_lo_r <= 1'h0;
      rd_valid <= 1'h0;
      rd_data <= {dpdbsi_pkg::DATA_RST, dpdbsi_pkg::DATA_RST};
    end else begin
      rd_valid <= (ph_r == dpdbsi_pkg::DPDBSI_PH_KLOW) && rv_lo_r && link.output_valid_flag;
      if (ph_r == dpdbsi_pkg::DPDBSI_PH_KRISE) begin
        rv_lo_r <= link.output_valid_flag;
        rlo_r <= link.rd_bus;
      end
      if ((ph_r == dpdbsi_pkg::DPDBSI_PH_KLOW) && rv_lo_r) begin
        rd_data <= {link.rd_bus, rlo_r};
      end
    end
  end

endmodule : dpdbsi_host_end

// ==== verif/dpdbsi_link_properties.sv ====
`timescale 1ns/1ns
// ****************************************************************
// Link checker, clocked by the link clocks
// ****************************************************************
module dpdbsi_link_properties (
  input wire logic k,
  input wire logic k_n,
  input wire logic rst_n,
  input wire logic pll_bypass_n,
  input wire logic read_port_select_n,
  input wire logic rd_data_oe,
  input wire logic output_valid_flag,
  input wire logic return_strobe,
  input wire logic return_strobe_n
);
  a_drive_needs_read: assert property ( // drive only for a read
    @(posedge k) disable iff (!rst_n) rd_data_oe |->
    (pll_bypass_n ? !$past(read_port_select_n, 3) : !$past(read_port_select_n, 2)))
    else $error("read bus driven without an accepted read");
  a_valid_at_kn: assert property ( // valid seen at k_n
    @(posedge k_n) disable iff (!rst_n) output_valid_flag |->
    (pll_bypass_n ? !$past(read_port_select_n, 2) : !$past(read_port_select_n, 1)))
    else $error("valid flag at k_n without an accepted read");
  a_strobe_copies_k: assert property ( // echo follows k
    @(negedge k) disable iff (!rst_n) return_strobe && !return_strobe_n)
    else $error("echo strobes not high low while k high");
  a_strobe_n_copies: assert property ( // echo follows k_n
    @(negedge k_n) disable iff (!rst_n) return_strobe_n && !return_strobe)
    else $error("echo strobes not low high while k_n high");
  a_pll_read_latency: assert property ( // two cycle latency
    @(posedge k) disable iff (!rst_n)
    !read_port_select_n && pll_bypass_n |-> ##3 output_valid_flag)
    else $error("read data not valid two cycles after accept");
  a_bypass_latency: assert property ( // one cycle latency
    @(posedge k) disable iff (!rst_n)
    !read_port_select_n && !pll_bypass_n |-> ##2 output_valid_flag)
    else $error("bypass read data not valid one cycle after accept");
  a_valid_has_read: assert property ( // valid needs a read
    @(posedge k) disable iff (!rst_n) output_valid_flag |->
    (pll_bypass_n ? !$past(read_port_select_n, 3) : !$past(read_port_select_n, 2)))
    else $error("valid data without an accepted read");
  a_burst_one_period: assert property ( // drive ends after burst
    @(posedge k) disable iff (!rst_n)
    !read_port_select_n ##1 read_port_select_n && pll_bypass_n
    |-> ##2 output_valid_flag ##1 !output_valid_flag)
    else $error("read drive not released after one burst");
endmodule : dpdbsi_link_properties

// ==== verif/tb.sv ====
`timescale 1ns/1ns
module tb;
  logic clk;
  logic rst_n;
  logic pll_bypass_n;
  logic termination_range_pin;
  logic term_high_range;
  logic cmd_valid;
  logic cmd_write;
  logic [dpdbsi_pkg::ADDR_W-1:0] cmd_addr;
  logic [2*dpdbsi_pkg::DATA_W-1:0] cmd_wdata;
  logic [2*dpdbsi_pkg::LANES-1:0] cmd_mask_n;
  logic cmd_ready;
  logic rd_valid;
  logic [2*dpdbsi_pkg::DATA_W-1:0] rd_data;
  logic [dpdbsi_pkg::DATA_W-1:0] wb0;
  logic [dpdbsi_pkg::DATA_W-1:0] wb1;
  logic [35:0] exp_q[$];
  int miscompares = 0;
  int check_count = 0;

  // ****************************************************************
  // Both ends joined by the link, checker beside it
  // ****************************************************************
  dpdbsi_link_if dpdbsi_link_if_i ();
  dpdbsi_host_end dpdbsi_host_end_i (.clk(clk), .rst_n(rst_n), .link(dpdbsi_link_if_i),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_mask_n(cmd_mask_n), .cmd_ready(cmd_ready),
    .rd_valid(rd_valid), .rd_data(rd_data));
  dpdbsi_device_end dpdbsi_device_end_i (.link(dpdbsi_link_if_i), .rst_n(rst_n),
    .pll_bypass_n(pll_bypass_n), .termination_range_pin(termination_range_pin),
    .term_high_range(term_high_range));
  dpdbsi_link_properties dpdbsi_link_properties_i (.k(dpdbsi_link_if_i.k),
    .k_n(dpdbsi_link_if_i.k_n), .rst_n(rst_n), .pll_bypass_n(pll_bypass_n),
    .read_port_select_n(dpdbsi_link_if_i.read_port_select_n),
    .rd_data_oe(dpdbsi_link_if_i.rd_data_oe),
    .output_valid_flag(dpdbsi_link_if_i.output_valid_flag),
    .return_strobe(dpdbsi_link_if_i.return_strobe),
    .return_strobe_n(dpdbsi_link_if_i.return_strobe_n));

  // ****************************************************************
  // Clock, compare and command tasks
  // ****************************************************************
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // Holds the command until the edge where ready is high
  task automatic send(input logic is_wr, input logic [20:0] a, input logic [35:0] d,
                      input logic [3:0] m);
    int n = 0;
    while (cmd_ready !== 1'h1 && n < 16) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(36'(cmd_ready), 36'h000000001); // launch slot offered
    cmd_valid = 1'h1;
    cmd_write = is_wr;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_mask_n = m;
    @(posedge clk);
    #1;
    cmd_valid = 1'h0;
  endtask : send

  task automatic wr(input logic [20:0] a, input logic [35:0] d, input logic [3:0] m);
    send(1'h1, a, d, m);
  endtask : wr

  task automatic rd(input logic [20:0] a, input logic [35:0] e);
    exp_q.push_back(e);
    send(1'h0, a, 36'h000000000, 4'hF);
  endtask : rd

  // Old and new words merged lane by lane, a high mask bit keeps the old lane
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                        input logic [3:0] m);
    logic [35:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i*9 +: 9] = m[i] ? o[i*9 +: 9] : n[i*9 +: 9];
    end
    return r;
  endfunction : merge

  task automatic bus_floats();
    check(36'(dpdbsi_link_if_i.rd_data_oe), 36'h000000000); // drivers off
  endtask : bus_floats

  // Waits for all expected reads, then looks at the idle bus
  task automatic drain(input string name);
    int n = 0;
    while (exp_q.size() != 0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (8) @(posedge clk);
    #1;
    check(36'(exp_q.size()), 36'h000000000); // every read answered
    bus_floats(); // released after burst
    $display("test %s done", name);
  endtask : drain

  task automatic do_reset(input logic byp, input logic term);
    rst_n = 1'h0;
    pll_bypass_n = byp;
    termination_range_pin = term;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'h1;
    repeat (30) @(posedge clk);
    #1;
    check(36'(term_high_range), 36'(term)); // strap range
  endtask : do_reset

  // Read results and the wire beats, one process so the order is fixed
  always @(negedge clk) begin
    if (rd_valid === 1'h1) begin
      if (exp_q.size() == 0) exp_q.push_back(36'hXXXXXXXXX);
      check(rd_data, exp_q[0]); // two-word burst
      check({wb1, wb0}, exp_q[0]); // beats on k and k_n
      void'(exp_q.pop_front());
    end
    if (dpdbsi_link_if_i.rd_data_oe === 1'h1) begin
      if (dpdbsi_link_if_i.k === 1'h1) wb0 = dpdbsi_link_if_i.rd_bus;
      else wb1 = dpdbsi_link_if_i.rd_bus;
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    cmd_valid = 1'h0;
    cmd_write = 1'h0;
    cmd_addr = 21'h000000;
    cmd_wdata = 36'h000000000;
    cmd_mask_n = 4'hF;
    do_reset(1'h1, 1'h1);
    bus_floats(); // idle after reset
    wr(21'h000000, 36'h123456789, 4'h0); // full write
    wr(21'h1FFFFF, 36'hFEDCBA987, 4'h0); // top address
    rd(21'h000000, 36'h123456789); // read back
    rd(21'h1FFFFF, 36'hFEDCBA987); // back to back
    wr(21'h000000, 36'h0F0F0F0F0, 4'h0); // overwrite
    rd(21'h000000, 36'h0F0F0F0F0); // newest data
    drain("full");
    for (int m = 0; m < 16; m++) begin
      wr(21'h000100 + 21'(m), 36'h555555555, 4'h0); // base pattern
      wr(21'h000100 + 21'(m), 36'hAAAAAAAAA, 4'(m)); // lane masks
      rd(21'h000100 + 21'(m), merge(36'h555555555, 36'hAAAAAAAAA, 4'(m))); // lanes kept
    end
    drain("masks");
    do_reset(1'h0, 1'h0); // low range
    wr(21'h0ABCDE, 36'h13579BDF0, 4'h0); // bypass write
    rd(21'h0ABCDE, 36'h13579BDF0); // bypass read
    rd(21'h0ABCDE, 36'h13579BDF0); // repeat read
    drain("bypass");
    finish_test();
  end

  // Cuts a hang short, far beyond the expected run length
  initial begin
    #800000;
    miscompares++;
    finish_test();
  end
endmodule : tb
